// ---- hdl/edmo_pkg.sv ----
// constants, types and register map of the extended data-memory execution unit
// assumes an apb master on the same clock and a byte-wide data memory of up to 2048 bytes
package edmo_pkg;
    localparam int ADDR_W = 11;
    localparam int MEM_DEPTH_DEF = 2048;
    localparam int INSTR_W = 19;

    // register byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_FLAGS = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_MADDR = 8'h10;
    localparam logic [7:0] OFF_MDATA = 8'h14;

    // status field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PEND_BIT = 1;
    localparam int ST_SKIP_BIT = 2;
    localparam int ST_SQCNT_LSB = 8;

    // reset values, and the all-ones byte that set byte writes
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [7:0] SQCNT_RST = 8'h00;
    localparam logic [7:0] MEM_ONES = 8'hff;

    typedef enum logic [4:0] {
        OP_MOVE_TO_ACC = 5'h00, OP_MOVE_TO_MEM = 5'h01,
        OP_OR_TO_ACC = 5'h02, OP_OR_TO_MEM = 5'h03,
        OP_ROT_LEFT = 5'h04, OP_ROT_LEFT_ACC = 5'h05,
        OP_ROT_LEFT_CARRY = 5'h06, OP_ROT_LEFT_CARRY_ACC = 5'h07,
        OP_ROT_RIGHT = 5'h08, OP_ROT_RIGHT_ACC = 5'h09,
        OP_ROT_RIGHT_CARRY = 5'h0a, OP_ROT_RIGHT_CARRY_ACC = 5'h0b,
        OP_SUB_BORROW_ACC = 5'h0c, OP_SUB_BORROW_MEM = 5'h0d,
        OP_DEC_SKIP_ZERO = 5'h0e, OP_DEC_SKIP_ZERO_ACC = 5'h0f,
        OP_SET_ONES = 5'h10, OP_SET_BIT = 5'h11,
        OP_INC_SKIP_ZERO = 5'h12, OP_INC_SKIP_ZERO_ACC = 5'h13,
        OP_BIT_SKIP_NONZERO = 5'h14
    } edmo_op_type;

    // one instruction word as written to the instruction register
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [2:0] bitsel;
        edmo_op_type op;
    } edmo_instr_type;

    typedef struct packed {
        logic cz;
        logic sc;
        logic ov;
        logic z;
        logic ac;
        logic c;
    } edmo_flags_type;

    typedef struct packed {
        logic [7:0] val;
        logic to_acc;
        logic to_mem;
        logic skip;
        edmo_flags_type flg;
    } edmo_res_type;

    // gray codes along idle, fetch, execute, squash
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC = 2'b11,
        ST_SQUASH = 2'b10
    } edmo_state_type;
endpackage

// ---- hdl/edmo_core.sv ----
// execution unit for the extended data-memory instruction group, with its own data memory
// assumes an apb master on pclk; one pclk edge stands for one instruction cycle
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
// Operation
// - move copies byte, flags untouched
// - or result to acc or mem, z only
// - rotate left, bit 7 into bit 0
// - rotate left through carry, carry only changes
// - rotate right, bit 0 into bit 7
// - rotate right through carry, carry only changes
// - accumulator rotates leave memory unchanged
// - acc minus mem minus inverted carry
// - carry clear on negative, else set
// - subtract updates ov z ac c sc cz
// - decrement memory, skip when zero
// - taken skip adds dummy third cycle
// - decrement to acc, memory unchanged
// - set byte writes all ones
// - set bit touches only selected bit
// - increment memory, skip when zero
// - increment to acc, memory unchanged
// - skip when selected bit is set
// - any memory address reachable directly
module edmo_core #(
    parameter int MEM_DEPTH = edmo_pkg::MEM_DEPTH_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    if (MEM_DEPTH < 2 || MEM_DEPTH > 2 ** edmo_pkg::ADDR_W) begin : g_bad_depth
        $error("edmo_core: MEM_DEPTH out of range");
    end

    function automatic logic op_known(input logic [4:0] code);
        op_known = code <= edmo_pkg::OP_BIT_SKIP_NONZERO;
    endfunction

    function automatic edmo_pkg::edmo_res_type exec_op(
        input edmo_pkg::edmo_instr_type i,
        input logic [7:0] a,
        input logic [7:0] m,
        input edmo_pkg::edmo_flags_type f
    );
        edmo_pkg::edmo_res_type r;
        logic [8:0] d;
        logic [4:0] dn;
        r = '0;
        r.flg = f;
        r.val = m;
        d = 9'h000;
        dn = 5'h00;
        case (i.op)
            edmo_pkg::OP_MOVE_TO_ACC: r.to_acc = 1'b1;
            edmo_pkg::OP_MOVE_TO_MEM: begin
                r.val = a;
                r.to_mem = 1'b1;
            end
            edmo_pkg::OP_OR_TO_ACC, edmo_pkg::OP_OR_TO_MEM: begin
                r.val = a | m;
                r.flg.z = (r.val == 8'h00);
                r.to_acc = (i.op == edmo_pkg::OP_OR_TO_ACC);
                r.to_mem = (i.op == edmo_pkg::OP_OR_TO_MEM);
            end
            edmo_pkg::OP_ROT_LEFT, edmo_pkg::OP_ROT_LEFT_ACC: begin
                r.val = {m[6:0], m[7]};
                r.to_acc = (i.op == edmo_pkg::OP_ROT_LEFT_ACC);
                r.to_mem = (i.op == edmo_pkg::OP_ROT_LEFT);
            end
            edmo_pkg::OP_ROT_LEFT_CARRY, edmo_pkg::OP_ROT_LEFT_CARRY_ACC: begin
                r.val = {m[6:0], f.c};
                r.flg.c = m[7];
                r.to_acc = (i.op == edmo_pkg::OP_ROT_LEFT_CARRY_ACC);
                r.to_mem = (i.op == edmo_pkg::OP_ROT_LEFT_CARRY);
            end
            edmo_pkg::OP_ROT_RIGHT, edmo_pkg::OP_ROT_RIGHT_ACC: begin
                r.val = {m[0], m[7:1]};
                r.to_acc = (i.op == edmo_pkg::OP_ROT_RIGHT_ACC);
                r.to_mem = (i.op == edmo_pkg::OP_ROT_RIGHT);
            end
            edmo_pkg::OP_ROT_RIGHT_CARRY, edmo_pkg::OP_ROT_RIGHT_CARRY_ACC: begin
                r.val = {f.c, m[7:1]};
                r.flg.c = m[0];
                r.to_acc = (i.op == edmo_pkg::OP_ROT_RIGHT_CARRY_ACC);
                r.to_mem = (i.op == edmo_pkg::OP_ROT_RIGHT_CARRY);
            end
            edmo_pkg::OP_SUB_BORROW_ACC, edmo_pkg::OP_SUB_BORROW_MEM: begin
                d = {1'b0, a} - {1'b0, m} - {8'h00, ~f.c};
                dn = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f.c};
                r.val = d[7:0];
                r.flg.c = ~d[8];
                r.flg.ac = ~dn[4];
                r.flg.ov = (a[7] ^ m[7]) & (a[7] ^ d[7]);
                r.flg.z = (d[7:0] == 8'h00);
                r.flg.sc = d[7] ^ r.flg.ov;
                // cz ands this byte's zero with the previous z flag, so it chains zero across two-byte subtracts
                r.flg.cz = (d[7:0] == 8'h00) & f.z;
                r.to_acc = (i.op == edmo_pkg::OP_SUB_BORROW_ACC);
                r.to_mem = (i.op == edmo_pkg::OP_SUB_BORROW_MEM);
            end
            edmo_pkg::OP_DEC_SKIP_ZERO, edmo_pkg::OP_DEC_SKIP_ZERO_ACC: begin
                r.val = m - 8'h01;
                r.skip = (r.val == 8'h00);
                r.to_acc = (i.op == edmo_pkg::OP_DEC_SKIP_ZERO_ACC);
                r.to_mem = (i.op == edmo_pkg::OP_DEC_SKIP_ZERO);
            end
            edmo_pkg::OP_SET_ONES: begin
                r.val = edmo_pkg::MEM_ONES;
                r.to_mem = 1'b1;
            end
            edmo_pkg::OP_SET_BIT: begin
                r.val = m | (8'h01 << i.bitsel);
                r.to_mem = 1'b1;
            end
            edmo_pkg::OP_INC_SKIP_ZERO, edmo_pkg::OP_INC_SKIP_ZERO_ACC: begin
                r.val = m + 8'h01;
                r.skip = (r.val == 8'h00);
                r.to_acc = (i.op == edmo_pkg::OP_INC_SKIP_ZERO_ACC);
                r.to_mem = (i.op == edmo_pkg::OP_INC_SKIP_ZERO);
            end
            edmo_pkg::OP_BIT_SKIP_NONZERO: r.skip = m[i.bitsel];
            default: r.skip = 1'b0;
        endcase
        return r;
    endfunction

    edmo_pkg::edmo_state_type st_q, st_d;
    edmo_pkg::edmo_instr_type cur_q, cur_d, pend_q, pend_d;
    edmo_pkg::edmo_flags_type flags_q, flags_d;
    edmo_pkg::edmo_res_type res;
    logic pv_q, pv_d, skip_q, skip_d;
    logic [7:0] acc_q, acc_d, opnd_q, opnd_d, sqcnt_q, sqcnt_d;
    logic [edmo_pkg::ADDR_W-1:0] maddr_q, maddr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [7:0] mem_q [MEM_DEPTH];
    logic [7:0] cur_rd, sw_rd, mem_wd;
    logic [edmo_pkg::ADDR_W-1:0] mem_wa;
    logic mem_we;
    logic setup, access, wr, busy, err, issue;
    edmo_pkg::edmo_instr_type wr_instr;

    // full-width address reaches every section without a bank select
    assign cur_rd = (cur_q.addr < MEM_DEPTH) ? mem_q[cur_q.addr] : 8'h00;
    assign sw_rd = (maddr_q < MEM_DEPTH) ? mem_q[maddr_q] : 8'h00;
    assign res = exec_op(cur_q, acc_q, opnd_q, flags_q);

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign busy = (st_q != edmo_pkg::ST_IDLE);
    assign wr_instr = edmo_pkg::edmo_instr_type'(pwdata[edmo_pkg::INSTR_W-1:0]);

    // software may only touch acc, flags and memory while nothing executes
    always_comb begin
        err = 1'b0;
        case (paddr)
            edmo_pkg::OFF_INSTR: err = pwrite & (~op_known(wr_instr.op) | (pv_q & busy));
            edmo_pkg::OFF_ACC, edmo_pkg::OFF_FLAGS, edmo_pkg::OFF_MDATA: err = pwrite & busy;
            edmo_pkg::OFF_STATUS: err = pwrite;
            edmo_pkg::OFF_MADDR: err = 1'b0;
            default: err = 1'b1;
        endcase
    end

    assign wr = access & pwrite & ~err;
    assign issue = wr & (paddr == edmo_pkg::OFF_INSTR);
    assign pready = access;
    assign pslverr = access & err;
    assign prdata = prdata_q;

    always_comb begin
        prdata_d = prdata_q;
        if (setup) begin
            case (paddr)
                edmo_pkg::OFF_INSTR: prdata_d = {13'h0000, cur_q};
                edmo_pkg::OFF_ACC: prdata_d = {24'h000000, acc_q};
                edmo_pkg::OFF_FLAGS: prdata_d = {26'h0000000, flags_q};
                edmo_pkg::OFF_STATUS: begin
                    prdata_d = 32'h00000000;
                    prdata_d[edmo_pkg::ST_BUSY_BIT] = busy;
                    prdata_d[edmo_pkg::ST_PEND_BIT] = pv_q;
                    prdata_d[edmo_pkg::ST_SKIP_BIT] = skip_q;
                    prdata_d[edmo_pkg::ST_SQCNT_LSB +: 8] = sqcnt_q;
                end
                edmo_pkg::OFF_MADDR: prdata_d = {21'h000000, maddr_q};
                edmo_pkg::OFF_MDATA: prdata_d = {24'h000000, sw_rd};
                default: prdata_d = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        pend_d = pend_q;
        pv_d = pv_q;
        opnd_d = opnd_q;
        acc_d = acc_q;
        flags_d = flags_q;
        skip_d = skip_q;
        sqcnt_d = sqcnt_q;
        maddr_d = maddr_q;
        mem_we = 1'b0;
        mem_wa = cur_q.addr;
        mem_wd = res.val;
        case (st_q)
            edmo_pkg::ST_IDLE: begin
                if (issue) begin
                    cur_d = wr_instr;
                    st_d = edmo_pkg::ST_FETCH;
                end
            end
            edmo_pkg::ST_FETCH: begin
                opnd_d = cur_rd;
                st_d = edmo_pkg::ST_EXEC;
                if (issue) begin
                    pend_d = wr_instr;
                    pv_d = 1'b1;
                end
            end
            edmo_pkg::ST_EXEC: begin
                mem_we = res.to_mem & (cur_q.addr < MEM_DEPTH);
                if (res.to_acc) begin
                    acc_d = res.val;
                end
                flags_d = res.flg;
                skip_d = res.skip;
                if (res.skip) begin
                    st_d = edmo_pkg::ST_SQUASH;
                    if (issue) begin
                        pend_d = wr_instr;
                        pv_d = 1'b1;
                    end
                end else if (pv_q) begin
                    cur_d = pend_q;
                    pv_d = 1'b0;
                    st_d = edmo_pkg::ST_FETCH;
                end else if (issue) begin
                    cur_d = wr_instr;
                    st_d = edmo_pkg::ST_FETCH;
                end else begin
                    st_d = edmo_pkg::ST_IDLE;
                end
            end
            edmo_pkg::ST_SQUASH: begin
                // the dummy cycle: the next instruction is dropped unexecuted
                if (pv_q | issue) begin
                    pv_d = 1'b0;
                    sqcnt_d = sqcnt_q + 8'h01;
                end
                st_d = edmo_pkg::ST_IDLE;
            end
            default: st_d = edmo_pkg::ST_IDLE;
        endcase
        if (wr) begin
            case (paddr)
                edmo_pkg::OFF_ACC: acc_d = pwdata[7:0];
                edmo_pkg::OFF_FLAGS: flags_d = edmo_pkg::edmo_flags_type'(pwdata[5:0]);
                edmo_pkg::OFF_MADDR: maddr_d = pwdata[edmo_pkg::ADDR_W-1:0];
                edmo_pkg::OFF_MDATA: begin
                    mem_we = (maddr_q < MEM_DEPTH);
                    mem_wa = maddr_q;
                    mem_wd = pwdata[7:0];
                end
                default: mem_wa = cur_q.addr;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= edmo_pkg::ST_IDLE;
            cur_q <= '0;
            pend_q <= '0;
            pv_q <= 1'b0;
            opnd_q <= edmo_pkg::ACC_RST;
            acc_q <= edmo_pkg::ACC_RST;
            flags_q <= edmo_pkg::FLAGS_RST;
            skip_q <= 1'b0;
            sqcnt_q <= edmo_pkg::SQCNT_RST;
            maddr_q <= '0;
            prdata_q <= 32'h00000000;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            pend_q <= pend_d;
            pv_q <= pv_d;
            opnd_q <= opnd_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
            skip_q <= skip_d;
            sqcnt_q <= sqcnt_d;
            maddr_q <= maddr_d;
            prdata_q <= prdata_d;
        end
    end

    // storage carries no reset: software loads it before use
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem_q[mem_wa] <= mem_wd;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic in_exec;
    assign in_exec = (st_q == edmo_pkg::ST_EXEC);

    sequence s_skip_taken;
        in_exec && res.skip;
    endsequence
    sequence s_dummy_then_done;
        ##1 (st_q == edmo_pkg::ST_SQUASH) ##1 (st_q == edmo_pkg::ST_IDLE);
    endsequence

    a_move_flags_kept: assert property (
        in_exec && cur_q.op inside {edmo_pkg::OP_MOVE_TO_ACC, edmo_pkg::OP_MOVE_TO_MEM} && !wr
        |=> flags_q == $past(flags_q))
        else $error("move changed a flag");
    a_or_to_acc: assert property (
        in_exec && cur_q.op == edmo_pkg::OP_OR_TO_ACC
        |=> acc_q == ($past(acc_q) | $past(opnd_q)) && flags_q.z == (acc_q == 8'h00))
        else $error("or to acc wrong");
    a_rot_left_mem: assert property (
        in_exec && cur_q.op == edmo_pkg::OP_ROT_LEFT
        |-> mem_we && mem_wd == {opnd_q[6:0], opnd_q[7]} && mem_wa == cur_q.addr)
        else $error("rotate left wrong");
    a_rlc_carry: assert property (
        in_exec && cur_q.op == edmo_pkg::OP_ROT_LEFT_CARRY_ACC
        |=> flags_q.c == $past(opnd_q[7]) && acc_q[0] == $past(flags_q.c))
        else $error("rotate left carry wrong");
    a_rot_right_acc: assert property (
        in_exec && cur_q.op == edmo_pkg::OP_ROT_RIGHT_ACC
        |=> acc_q == {$past(opnd_q[0]), $past(opnd_q[7:1])})
        else $error("rotate right wrong");
    a_rrc_carry: assert property (
        in_exec && cur_q.op == edmo_pkg::OP_ROT_RIGHT_CARRY
        |-> mem_wd[7] == flags_q.c ##1 flags_q.c == $past(opnd_q[0]))
        else $error("rotate right carry wrong");
    a_acc_rot_mem: assert property (
        in_exec && cur_q.op inside {edmo_pkg::OP_ROT_LEFT_ACC, edmo_pkg::OP_ROT_RIGHT_ACC,
        edmo_pkg::OP_ROT_LEFT_CARRY_ACC, edmo_pkg::OP_ROT_RIGHT_CARRY_ACC} |-> !mem_we)
        else $error("acc rotate wrote memory");
    a_sbc_carry: assert property (
        in_exec && cur_q.op == edmo_pkg::OP_SUB_BORROW_ACC
        |=> flags_q.c == ({1'b0, $past(acc_q)} >= ({1'b0, $past(opnd_q)} + {8'h00, ~$past(flags_q.c)})))
        else $error("borrow carry wrong");
    a_skip_three: assert property (
        s_skip_taken |-> s_dummy_then_done)
        else $error("skip lacks dummy cycle");
    a_set_ones: assert property (
        in_exec && cur_q.op == edmo_pkg::OP_SET_ONES |-> mem_we && mem_wd == 8'hff)
        else $error("set byte wrong");
    a_bit_skip: assert property (
        in_exec && cur_q.op == edmo_pkg::OP_BIT_SKIP_NONZERO
        |-> res.skip == opnd_q[cur_q.bitsel] && !mem_we)
        else $error("bit test skip wrong");
    a_squash_drop: assert property (
        st_q == edmo_pkg::ST_SQUASH && (pv_q || issue)
        |=> !pv_q && st_q == edmo_pkg::ST_IDLE && sqcnt_q == $past(sqcnt_q) + 8'h01)
        else $error("squash kept next instruction");
endmodule

// ---- dv/edmo_apb_master.sv ----
// apb master model standing in for the decoder side of the execution unit
// assumes one caller at a time and a slave on the same pclk
`timescale 1ns/10ps
module edmo_apb_master (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one setup cycle, then access until pready; ok stays low if the slave never answers
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        ok = 1'h0;
        rd = 32'h0;
        err = 1'h0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (n = 0; n < 16 && ok !== 1'h1; n++) begin
            @(posedge pclk);
            if (pready === 1'h1) begin
                ok = 1'h1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'h0;
        penable <= 1'h0;
        // released bus shows inverted values so the slave cannot lean on stale ones
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ---- dv/edmo_core_test.sv ----
// self-checking bench for the extended data-memory execution unit
// assumes edmo_pkg and the apb master model are compiled first
`timescale 1ns/10ps
module edmo_core_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int n_fail;
    int total_checks;

    edmo_core edmo_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    edmo_apb_master edmo_apb_master_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic end_sim();
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic eerr,
                      output logic [31:0] rd);
        logic err;
        logic ok;
        edmo_apb_master_inst.xfer(w, a, d, rd, err, ok);
        if (ok !== 1'h1) begin
            n_fail++;
            $display("CHECK FAILED pready expected 1 seen %b", ok);
            end_sim();
        end
        chk("pslverr", {31'h0, eerr}, {31'h0, err});
    endtask

    // busy and pending both clear, within a bounded number of polls
    task automatic wait_idle();
        logic [31:0] st;
        int n;
        st = 32'h3;
        for (n = 0; n < 20 && st[1:0] !== 2'h0; n++) begin
            xf(1'h0, edmo_pkg::OFF_STATUS, 32'h0, 1'h0, st);
        end
        if (st[1:0] !== 2'h0) begin
            n_fail++;
            $display("CHECK FAILED idle expected 0 seen %h", st[1:0]);
            end_sim();
        end
    endtask

    task automatic mset(input logic [10:0] ad, input logic [7:0] v);
        logic [31:0] rd;
        xf(1'h1, edmo_pkg::OFF_MADDR, {21'h0, ad}, 1'h0, rd);
        xf(1'h1, edmo_pkg::OFF_MDATA, {24'h0, v}, 1'h0, rd);
    endtask

    task automatic mchk(input logic [10:0] ad, input logic [7:0] v);
        logic [31:0] rd;
        xf(1'h1, edmo_pkg::OFF_MADDR, {21'h0, ad}, 1'h0, rd);
        xf(1'h0, edmo_pkg::OFF_MDATA, 32'h0, 1'h0, rd);
        chk("mem", {24'h0, v}, rd);
    endtask

    // preload acc, flags and one byte, run one instruction, compare everything it may touch
    task automatic run(input logic [4:0] op, input logic [2:0] bs, input logic [10:0] ad,
                       input logic [7:0] a0, input logic [7:0] m0, input logic [5:0] f0,
                       input logic [7:0] ea, input logic [7:0] em, input logic [5:0] ef, input logic es);
        logic [31:0] rd;
        mset(ad, m0);
        xf(1'h1, edmo_pkg::OFF_ACC, {24'h0, a0}, 1'h0, rd);
        xf(1'h1, edmo_pkg::OFF_FLAGS, {26'h0, f0}, 1'h0, rd);
        xf(1'h1, edmo_pkg::OFF_INSTR, {13'h0, ad, bs, op}, 1'h0, rd);
        wait_idle();
        xf(1'h0, edmo_pkg::OFF_INSTR, 32'h0, 1'h0, rd);
        chk("instr", {13'h0, ad, bs, op}, rd);
        xf(1'h0, edmo_pkg::OFF_ACC, 32'h0, 1'h0, rd);
        chk("acc", {24'h0, ea}, rd);
        xf(1'h0, edmo_pkg::OFF_FLAGS, 32'h0, 1'h0, rd);
        chk("flags", {26'h0, ef}, rd);
        mchk(ad, em);
        xf(1'h0, edmo_pkg::OFF_STATUS, 32'h0, 1'h0, rd);
        chk("skip", {31'h0, es}, {31'h0, rd[edmo_pkg::ST_SKIP_BIT]});
    endtask

    // dec-skip followed at once by a move; the move survives only when no skip is taken
    task automatic squash(input logic [7:0] m0, input logic [7:0] em, input logic [7:0] cinc);
        logic [31:0] rd;
        logic [7:0] cnt;
        mset(11'h055, 8'h00);
        mset(11'h0aa, m0);
        xf(1'h1, edmo_pkg::OFF_ACC, 32'haa, 1'h0, rd);
        xf(1'h0, edmo_pkg::OFF_STATUS, 32'h0, 1'h0, rd);
        cnt = rd[15:8];
        xf(1'h1, edmo_pkg::OFF_INSTR, {13'h0, 11'h0aa, 3'h0, 5'h0e}, 1'h0, rd);
        xf(1'h1, edmo_pkg::OFF_INSTR, {13'h0, 11'h055, 3'h0, 5'h01}, 1'h0, rd);
        wait_idle();
        xf(1'h0, edmo_pkg::OFF_STATUS, 32'h0, 1'h0, rd);
        chk("squash_cnt", {24'h0, cnt + cinc}, {24'h0, rd[15:8]});
        mchk(11'h055, em);
    endtask

    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        logic [31:0] rd;
        n_fail = 0;
        total_checks = 0;
        presetn = 1'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        xf(1'h0, edmo_pkg::OFF_ACC, 32'h0, 1'h0, rd);
        chk("acc_rst", {24'h0, edmo_pkg::ACC_RST}, rd);
        xf(1'h0, edmo_pkg::OFF_FLAGS, 32'h0, 1'h0, rd);
        chk("flags_rst", {26'h0, edmo_pkg::FLAGS_RST}, rd);
        xf(1'h0, edmo_pkg::OFF_STATUS, 32'h0, 1'h0, rd);
        chk("status_rst", 32'h0, rd);
        xf(1'h1, 8'h18, 32'h0, 1'h1, rd);
        xf(1'h1, 8'h02, 32'h0, 1'h1, rd);
        xf(1'h1, edmo_pkg::OFF_STATUS, 32'h0, 1'h1, rd);
        xf(1'h1, edmo_pkg::OFF_INSTR, 32'h15, 1'h1, rd);
        run(5'h00, 3'h0, 11'h7ff, 8'h00, 8'ha5, 6'h3f, 8'ha5, 8'ha5, 6'h3f, 1'h0);
        run(5'h01, 3'h0, 11'h000, 8'h3c, 8'h00, 6'h15, 8'h3c, 8'h3c, 6'h15, 1'h0);
        run(5'h02, 3'h0, 11'h400, 8'h0f, 8'h30, 6'h3f, 8'h3f, 8'h30, 6'h3b, 1'h0);
        run(5'h03, 3'h0, 11'h401, 8'h00, 8'h00, 6'h00, 8'h00, 8'h00, 6'h04, 1'h0);
        run(5'h04, 3'h0, 11'h123, 8'h55, 8'h81, 6'h00, 8'h55, 8'h03, 6'h00, 1'h0);
        run(5'h05, 3'h0, 11'h124, 8'h00, 8'h81, 6'h3e, 8'h03, 8'h81, 6'h3e, 1'h0);
        run(5'h06, 3'h0, 11'h200, 8'h00, 8'h80, 6'h3e, 8'h00, 8'h00, 6'h3f, 1'h0);
        run(5'h07, 3'h0, 11'h201, 8'h00, 8'h01, 6'h01, 8'h03, 8'h01, 6'h00, 1'h0);
        run(5'h08, 3'h0, 11'h300, 8'h11, 8'h01, 6'h01, 8'h11, 8'h80, 6'h01, 1'h0);
        run(5'h09, 3'h0, 11'h301, 8'h00, 8'h02, 6'h00, 8'h01, 8'h02, 6'h00, 1'h0);
        run(5'h0a, 3'h0, 11'h302, 8'h00, 8'h01, 6'h3e, 8'h00, 8'h00, 6'h3f, 1'h0);
        run(5'h0b, 3'h0, 11'h303, 8'h22, 8'h00, 6'h01, 8'h80, 8'h00, 6'h00, 1'h0);
        run(5'h0c, 3'h0, 11'h500, 8'h05, 8'h03, 6'h01, 8'h02, 8'h03, 6'h03, 1'h0);
        run(5'h0c, 3'h0, 11'h501, 8'h05, 8'h05, 6'h00, 8'hff, 8'h05, 6'h10, 1'h0);
        run(5'h0d, 3'h0, 11'h502, 8'h80, 8'h01, 6'h01, 8'h80, 8'h7f, 6'h19, 1'h0);
        run(5'h0c, 3'h0, 11'h503, 8'h10, 8'h10, 6'h05, 8'h00, 8'h10, 6'h27, 1'h0);
        run(5'h0e, 3'h0, 11'h600, 8'h00, 8'h01, 6'h3f, 8'h00, 8'h00, 6'h3f, 1'h1);
        run(5'h0e, 3'h0, 11'h601, 8'h00, 8'h00, 6'h00, 8'h00, 8'hff, 6'h00, 1'h0);
        run(5'h0f, 3'h0, 11'h602, 8'h55, 8'h01, 6'h00, 8'h00, 8'h01, 6'h00, 1'h1);
        run(5'h0f, 3'h0, 11'h603, 8'h55, 8'h02, 6'h00, 8'h01, 8'h02, 6'h00, 1'h0);
        run(5'h10, 3'h0, 11'h700, 8'h00, 8'h12, 6'h15, 8'h00, 8'hff, 6'h15, 1'h0);
        run(5'h11, 3'h7, 11'h701, 8'h00, 8'h00, 6'h2a, 8'h00, 8'h80, 6'h2a, 1'h0);
        run(5'h11, 3'h0, 11'h702, 8'h00, 8'h7e, 6'h00, 8'h00, 8'h7f, 6'h00, 1'h0);
        run(5'h12, 3'h0, 11'h080, 8'h00, 8'hff, 6'h00, 8'h00, 8'h00, 6'h00, 1'h1);
        run(5'h12, 3'h0, 11'h081, 8'h00, 8'h7f, 6'h3f, 8'h00, 8'h80, 6'h3f, 1'h0);
        run(5'h13, 3'h0, 11'h082, 8'h12, 8'hff, 6'h00, 8'h00, 8'hff, 6'h00, 1'h1);
        run(5'h14, 3'h3, 11'h083, 8'h00, 8'h08, 6'h3f, 8'h00, 8'h08, 6'h3f, 1'h1);
        run(5'h14, 3'h3, 11'h084, 8'h00, 8'hf7, 6'h00, 8'h00, 8'hf7, 6'h00, 1'h0);
        squash(8'h01, 8'h00, 8'h01);
        squash(8'h05, 8'haa, 8'h00);
        // mid-run reset clears state and the squash count but leaves memory alone
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        xf(1'h0, edmo_pkg::OFF_STATUS, 32'h0, 1'h0, rd);
        chk("status_rst2", 32'h0, rd);
        xf(1'h0, edmo_pkg::OFF_ACC, 32'h0, 1'h0, rd);
        chk("acc_rst2", {24'h0, edmo_pkg::ACC_RST}, rd);
        mchk(11'h055, 8'haa);
        end_sim();
    end
endmodule
